// ===== mft_pkg.sv
// package: constants, carriers and state types of the mac fifo threshold block
package mft_pkg;
   localparam int FIFO_BYTES = 32;
   localparam logic [5:0] CNT_FULL = 6'h20;
   localparam logic [5:0] CNT_TX_ROOM = 6'h1e;
   localparam logic [5:0] CNT_RST = 6'h00;
   localparam logic [4:0] PTR_RST = 5'h00;
   localparam logic [4:0] PTR_STEP_WORD = 5'h02;
   localparam logic [7:0] PAD_BYTE = 8'hff;
   // word counts per select code, nibble n holds code n (3..0 = 12,8,4,2 words)
   localparam logic [15:0] THR_MAP_DEF = 16'hc842;

   typedef struct packed {
      logic byte_order_select;
      logic block_transfer_select;
      logic [1:0] rx_fifo_threshold_sel;
      logic [1:0] tx_fifo_threshold_sel;
   } mft_cfg_t;

   typedef enum logic [3:0] {
      RX_DATA = 4'h1,
      RX_PAD = 4'h2,
      RX_ST0 = 4'h4,
      RX_ST1 = 4'h8
   } mft_rx_state_t;

   typedef enum logic [2:0] {
      DMA_IDLE = 3'h1,
      DMA_REQ = 3'h2,
      DMA_BURST = 3'h4
   } mft_dma_state_t;

   typedef struct packed {
      logic [31:0][7:0] b;
      logic [4:0] wp;
      logic [4:0] rp;
      logic [5:0] cnt;
      mft_rx_state_t st;
      logic [15:0] status;
      logic [5:0] flush;
      mft_dma_state_t dma;
      logic [4:0] beats;
   } mft_rx_reg_t;

   typedef struct packed {
      logic [31:0][7:0] b;
      logic [31:0] vld;
      logic [4:0] wp;
      logic [4:0] rp;
      logic [5:0] cnt;
      mft_dma_state_t dma;
      logic [4:0] beats;
      logic active;
      logic eop;
      logic run;
      logic [7:0] ob;
      logic ob_v;
   } mft_tx_reg_t;

   localparam mft_rx_reg_t RX_RST = '{b: '0, wp: PTR_RST, rp: PTR_RST, cnt: CNT_RST,
      st: RX_DATA, status: 16'h0000, flush: CNT_RST, dma: DMA_IDLE, beats: 5'h00};
   localparam mft_tx_reg_t TX_RST = '{b: '0, vld: 32'h00000000, wp: PTR_RST, rp: PTR_RST,
      cnt: CNT_RST, dma: DMA_IDLE, beats: 5'h00, active: 1'b0, eop: 1'b0, run: 1'b0,
      ob: 8'h00, ob_v: 1'b0};
endpackage

// ===== mft_lane_map.sv
// byte index to storage slot, honouring the byte order select
`timescale 1ns/10ps
module mft_lane_map (
   input wire logic [4:0] idx,
   input wire logic be,
   output logic [4:0] slot
);
   // big endian fills each entry from its top lane down
   assign slot = {idx[4:2], be ? ~idx[1:0] : idx[1:0]};
endmodule // mft_lane_map

// ===== mft_thr_cmp.sv
// threshold decode and strict greater-than compare on a fifo byte count
`timescale 1ns/10ps
module mft_thr_cmp #(
   parameter logic [15:0] MAP = mft_pkg::THR_MAP_DEF
) (
   input wire logic [1:0] sel,
   input wire logic [5:0] cnt,
   output logic [4:0] words,
   output logic above
);
   logic [3:0] w;
   assign w = MAP[{sel, 2'b00} +: 4];
   assign words = {1'b0, w};
   assign above = cnt > {1'b0, w, 1'b0};
endmodule // mft_thr_cmp

// ===== mft_fifo_dma.sv
// mac-side byte fifos with threshold driven dma bursts for rx and tx
//
// Functional notes
// R01: little endian: first byte in bits 7:0
// R02: big endian: first byte in bits 15:8
// R03: two independent 32-byte fifos, rx and tx
// R04: 8 entries of 4 bytes, byte-steered writes
// R05: rx request only when count exceeds threshold; code also requests to drain a finished packet's tail
// R06: rx re-requests immediately while still above threshold; code re-requests after one idle cycle
// R07: block mode moves threshold bytes per request
// R08: empty/fill mode empties rx, fills tx
// R09: odd packet end padded with 0ffh
// R10: packet status follows last data or pad
// R11: rx drained only as whole aligned words
// R12: each dma beat is one entry half
// R13: tx fetches words before transmission starts
// R14: tx reader starts when count exceeds threshold; code also starts once the packet's last word is in
// R15: tx requests while count at most threshold
// R16: tx block mode loads threshold bytes per grant
// R17: tx reader orders, counts, drops extraneous bytes
// R18: tx accepts packets at any byte address
// R19: status and configuration words are 16 bits
// R20: threshold code to word count is parameter
`timescale 1ns/10ps
module mft_fifo_dma #(
   parameter logic [15:0] RX_THR_MAP = mft_pkg::THR_MAP_DEF,
   parameter logic [15:0] TX_THR_MAP = mft_pkg::THR_MAP_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire mft_pkg::mft_cfg_t cfg,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   output logic rx_byte_ready,
   input wire logic rx_end,
   input wire logic [15:0] rx_status,
   output logic rx_dma_req,
   input wire logic rx_dma_gnt,
   output logic rx_dma_valid,
   input wire logic rx_dma_ready,
   output logic [15:0] rx_dma_data,
   output logic rx_dma_last,
   input wire logic tx_start,
   output logic tx_dma_req,
   input wire logic tx_dma_gnt,
   input wire logic tx_dma_valid,
   output logic tx_dma_ready,
   input wire logic [15:0] tx_dma_data,
   input wire logic [1:0] tx_dma_byte_en,
   input wire logic tx_dma_eop,
   output logic tx_byte_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_byte_ready,
   output logic tx_packet_done
);
   logic [1:0] rst_sync_reg;
   logic rst_int_n;
   mft_pkg::mft_rx_reg_t rx_reg;
   mft_pkg::mft_rx_reg_t rx_next;
   mft_pkg::mft_tx_reg_t tx_reg;
   mft_pkg::mft_tx_reg_t tx_next;
   logic be;
   logic rx_above;
   logic [4:0] rx_thr_words;
   logic tx_above;
   logic [4:0] tx_thr_words;
   logic [4:0] rx_wslot;
   logic [4:0] rx_rslot0;
   logic [4:0] rx_rslot1;
   logic [4:0] tx_wslot0;
   logic [4:0] tx_wslot1;
   logic [4:0] tx_rslot;
   logic [4:0] rx_rp1;
   logic [4:0] tx_wp1;
   logic rx_push;
   logic [7:0] rx_wbyte;
   logic rx_pop;
   logic rx_space;
   logic tx_wr;
   logic tx_pop;
   logic tx_take;
   logic tx_done;

   // reset released through two flops so every state flop leaves reset together
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_reg[1];

   assign be = cfg.byte_order_select;
   assign rx_rp1 = rx_reg.rp + 5'h01;
   assign tx_wp1 = tx_reg.wp + 5'h01;

   mft_thr_cmp #(.MAP(RX_THR_MAP)) u_rx_thr ( // R20
      .sel(cfg.rx_fifo_threshold_sel),
      .cnt(rx_reg.cnt),
      .words(rx_thr_words),
      .above(rx_above)
   );

   mft_thr_cmp #(.MAP(TX_THR_MAP)) u_tx_thr ( // R20
      .sel(cfg.tx_fifo_threshold_sel),
      .cnt(tx_reg.cnt),
      .words(tx_thr_words),
      .above(tx_above)
   );

   mft_lane_map u_rx_wmap ( // R04
      .idx(rx_reg.wp),
      .be(be),
      .slot(rx_wslot)
   );

   mft_lane_map u_rx_rmap0 (
      .idx(rx_reg.rp),
      .be(be),
      .slot(rx_rslot0)
   );

   mft_lane_map u_rx_rmap1 (
      .idx(rx_rp1),
      .be(be),
      .slot(rx_rslot1)
   );

   mft_lane_map u_tx_wmap0 (
      .idx(tx_reg.wp),
      .be(be),
      .slot(tx_wslot0)
   );

   mft_lane_map u_tx_wmap1 (
      .idx(tx_wp1),
      .be(be),
      .slot(tx_wslot1)
   );

   mft_lane_map u_tx_rmap ( // R17
      .idx(tx_reg.rp),
      .be(be),
      .slot(tx_rslot)
   );

   // ---------------- receive path ----------------
   assign rx_space = rx_reg.cnt < mft_pkg::CNT_FULL;
   // an end marker takes the cycle; a byte offered with it is not taken
   assign rx_byte_ready = (rx_reg.st == mft_pkg::RX_DATA) && rx_space && !rx_end;
   assign rx_dma_req = rx_reg.dma == mft_pkg::DMA_REQ;
   assign rx_dma_valid = rx_reg.dma == mft_pkg::DMA_BURST;
   assign rx_dma_last = rx_dma_valid && (rx_reg.beats == 5'h01);
   // the two bytes of one entry half, first byte placed by byte order
   assign rx_dma_data = be ? {rx_reg.b[rx_rslot0], rx_reg.b[rx_rslot1]} // R02 R12
                           : {rx_reg.b[rx_rslot1], rx_reg.b[rx_rslot0]}; // R01 R11

   always_comb begin
      rx_next = rx_reg;
      rx_push = 1'b0;
      rx_wbyte = rx_byte;
      rx_pop = rx_dma_valid && rx_dma_ready;
      case (rx_reg.st)
         mft_pkg::RX_DATA: begin
            if (rx_end) begin
               rx_next.status = rx_status; // R19
               // packets start word aligned, so the write pointer tells the parity
               rx_next.st = rx_reg.wp[0] ? mft_pkg::RX_PAD : mft_pkg::RX_ST0; // R09
            end else if (rx_byte_valid && rx_space) begin
               rx_push = 1'b1;
            end
         end
         mft_pkg::RX_PAD: begin
            if (rx_space) begin
               rx_push = 1'b1;
               rx_wbyte = mft_pkg::PAD_BYTE; // R09
               rx_next.st = mft_pkg::RX_ST0;
            end
         end
         mft_pkg::RX_ST0: begin
            if (rx_space) begin
               rx_push = 1'b1;
               rx_wbyte = be ? rx_reg.status[15:8] : rx_reg.status[7:0]; // R10
               rx_next.st = mft_pkg::RX_ST1;
            end
         end
         mft_pkg::RX_ST1: begin
            if (rx_space) begin
               rx_push = 1'b1;
               rx_wbyte = be ? rx_reg.status[7:0] : rx_reg.status[15:8]; // R10
               rx_next.st = mft_pkg::RX_DATA;
            end
         end
         default: begin
            rx_next.st = mft_pkg::RX_DATA;
         end
      endcase

      if (rx_push) begin
         rx_next.b[rx_wslot] = rx_wbyte; // R03 R04
         rx_next.wp = rx_reg.wp + 5'h01;
      end
      if (rx_pop) begin
         rx_next.rp = rx_reg.rp + mft_pkg::PTR_STEP_WORD; // R11
      end
      rx_next.cnt = rx_reg.cnt + {5'h00, rx_push} - (rx_pop ? 6'h02 : 6'h00);

      // a finished packet's tail is drained even below threshold
      if (rx_push && (rx_reg.st == mft_pkg::RX_ST1)) begin
         rx_next.flush = rx_next.cnt; // R10
      end else if (rx_pop && (rx_reg.flush >= 6'h02)) begin
         rx_next.flush = rx_reg.flush - 6'h02;
      end

      case (rx_reg.dma)
         mft_pkg::DMA_IDLE: begin
            if (rx_above || (rx_reg.flush != mft_pkg::CNT_RST)) begin // R05 R06
               rx_next.dma = mft_pkg::DMA_REQ;
            end
         end
         mft_pkg::DMA_REQ: begin
            if (rx_dma_gnt) begin
               rx_next.dma = mft_pkg::DMA_BURST;
               if (!cfg.block_transfer_select) begin
                  rx_next.beats = rx_reg.cnt[5:1]; // R08
               end else if (rx_above) begin
                  rx_next.beats = rx_thr_words; // R07
               end else begin
                  rx_next.beats = rx_reg.flush[5:1];
               end
            end
         end
         mft_pkg::DMA_BURST: begin
            if (rx_pop) begin
               rx_next.beats = rx_reg.beats - 5'h01;
               if (rx_reg.beats == 5'h01) begin
                  rx_next.dma = mft_pkg::DMA_IDLE;
               end
            end
         end
         default: begin
            rx_next.dma = mft_pkg::DMA_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         rx_reg <= mft_pkg::RX_RST;
      end else begin
         rx_reg <= rx_next;
      end
   end

   // ---------------- transmit path ----------------
   assign tx_dma_req = tx_reg.dma == mft_pkg::DMA_REQ;
   assign tx_dma_ready = (tx_reg.dma == mft_pkg::DMA_BURST)
      && (tx_reg.cnt <= mft_pkg::CNT_TX_ROOM);
   assign tx_wr = tx_dma_ready && tx_dma_valid;
   assign tx_byte_valid = tx_reg.ob_v;
   assign tx_byte = tx_reg.ob;
   assign tx_take = !tx_reg.ob_v || tx_byte_ready;
   assign tx_done = tx_reg.run && tx_reg.eop && (tx_reg.cnt == mft_pkg::CNT_RST) && tx_take;
   assign tx_packet_done = tx_done;

   always_comb begin
      tx_next = tx_reg;
      tx_pop = 1'b0;

      if (!tx_reg.active && !tx_reg.run && tx_start) begin
         tx_next.active = 1'b1;
         tx_next.eop = 1'b0;
      end

      case (tx_reg.dma)
         mft_pkg::DMA_IDLE: begin
            // refill requests stop once the packet's last word is in
            if (tx_reg.active && !tx_reg.eop && !tx_above) begin // R13 R15
               tx_next.dma = mft_pkg::DMA_REQ;
            end
         end
         mft_pkg::DMA_REQ: begin
            if (tx_dma_gnt) begin
               tx_next.dma = mft_pkg::DMA_BURST;
               if (cfg.block_transfer_select) begin
                  tx_next.beats = tx_thr_words; // R16
               end else begin
                  tx_next.beats = 5'((mft_pkg::CNT_FULL - tx_reg.cnt) >> 1); // R08
               end
            end
         end
         mft_pkg::DMA_BURST: begin
            if (tx_wr) begin
               tx_next.beats = tx_reg.beats - 5'h01;
               if ((tx_reg.beats == 5'h01) || tx_dma_eop) begin
                  tx_next.dma = mft_pkg::DMA_IDLE;
               end
            end
         end
         default: begin
            tx_next.dma = mft_pkg::DMA_IDLE;
         end
      endcase

      if (tx_wr) begin
         // byte enables mark the bytes of an odd start or end address
         tx_next.b[tx_wslot0] = be ? tx_dma_data[15:8] : tx_dma_data[7:0]; // R01 R02 R12
         tx_next.b[tx_wslot1] = be ? tx_dma_data[7:0] : tx_dma_data[15:8];
         tx_next.vld[tx_wslot0] = tx_dma_byte_en[0]; // R18
         tx_next.vld[tx_wslot1] = tx_dma_byte_en[1]; // R18
         tx_next.wp = tx_reg.wp + mft_pkg::PTR_STEP_WORD;
         if (tx_dma_eop) begin
            tx_next.eop = 1'b1;
         end
      end

      // a short packet that never crosses the threshold still goes once complete
      if (tx_reg.active && !tx_reg.run && (tx_above || tx_reg.eop)) begin // R14
         tx_next.run = 1'b1;
      end

      if (tx_reg.ob_v && tx_byte_ready) begin
         tx_next.ob_v = 1'b0;
      end
      if (tx_reg.run && (tx_reg.cnt != mft_pkg::CNT_RST)) begin
         if (!tx_reg.vld[tx_rslot]) begin
            tx_pop = 1'b1; // R17
         end else if (tx_take) begin
            tx_next.ob = tx_reg.b[tx_rslot]; // R17
            tx_next.ob_v = 1'b1;
            tx_pop = 1'b1;
         end
      end
      if (tx_pop) begin
         tx_next.rp = tx_reg.rp + 5'h01;
      end
      tx_next.cnt = tx_reg.cnt + (tx_wr ? 6'h02 : 6'h00) - {5'h00, tx_pop}; // R03

      if (tx_done) begin
         tx_next.run = 1'b0;
         tx_next.active = 1'b0;
         tx_next.eop = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         tx_reg <= mft_pkg::TX_RST;
      end else begin
         tx_reg <= tx_next;
      end
   end
endmodule // mft_fifo_dma

// ===== mft_fifo_dma_assertions.sv
// checker: port-level timing properties of the mac fifo threshold block
`timescale 1ns/10ps
module mft_fifo_dma_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_end,
   input wire logic rx_byte_ready,
   input wire logic rx_dma_req,
   input wire logic rx_dma_gnt,
   input wire logic rx_dma_valid,
   input wire logic rx_dma_ready,
   input wire logic [15:0] rx_dma_data,
   input wire logic rx_dma_last,
   input wire logic tx_dma_req,
   input wire logic tx_dma_gnt,
   input wire logic tx_dma_ready,
   input wire logic tx_byte_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_byte_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_rx_gnt_burst: assert property (rx_dma_req && rx_dma_gnt |=> rx_dma_valid)
      else $error("rx burst not started after grant");
   a_rx_word_hold: assert property (rx_dma_valid && !rx_dma_ready |=>
      rx_dma_valid && $stable(rx_dma_data)) else $error("rx word changed before taken");
   a_rx_last_beat: assert property (rx_dma_valid && rx_dma_ready && !rx_dma_last |=>
      rx_dma_valid) else $error("burst ended before its last beat");
   a_rx_end_block: assert property (rx_end |-> !rx_byte_ready [*3])
      else $error("bytes accepted while pad or status written");
   a_rx_idle_gap: assert property (rx_dma_valid && rx_dma_ready && rx_dma_last |=>
      !rx_dma_valid && !rx_dma_req) else $error("no idle cycle after burst");
   a_rx_req_hold: assert property (rx_dma_req && !rx_dma_gnt |=> rx_dma_req)
      else $error("rx request withdrawn before grant");
   a_tx_gnt_fill: assert property (tx_dma_req && tx_dma_gnt |=> tx_dma_ready)
      else $error("tx burst not started after grant");
   a_tx_byte_hold: assert property (tx_byte_valid && !tx_byte_ready |=>
      tx_byte_valid && $stable(tx_byte)) else $error("tx byte changed before taken");
endmodule // mft_fifo_dma_assertions
bind mft_fifo_dma mft_fifo_dma_assertions i_mft_fifo_dma_assertions (.clk, .rst_n, .rx_end,
   .rx_byte_ready, .rx_dma_req, .rx_dma_gnt, .rx_dma_valid, .rx_dma_ready, .rx_dma_data,
   .rx_dma_last, .tx_dma_req, .tx_dma_gnt, .tx_dma_ready, .tx_byte_valid, .tx_byte,
   .tx_byte_ready);

// ===== mft_mem_model.sv
// memory-side model: grants tenures, stores rx words, sources tx words
`timescale 1ns/10ps
module mft_mem_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic rx_dma_req,
   output logic rx_dma_gnt = 1'b0,
   input wire logic rx_dma_valid,
   output logic rx_dma_ready = 1'b0,
   input wire logic [15:0] rx_dma_data,
   input wire logic tx_dma_req,
   output logic tx_dma_gnt = 1'b0,
   output logic tx_dma_valid = 1'b0,
   input wire logic tx_dma_ready,
   output logic [15:0] tx_dma_data,
   output logic [1:0] tx_dma_byte_en,
   output logic tx_dma_eop
);
   logic [15:0] rx_mem [0:63];
   logic [18:0] tx_mem [0:63];
   int rx_n = 0;
   int ti = 0;
   logic tick = 1'b0;
   // slow mode delays grants and stalls the rx side every other cycle
   always @(posedge clk) begin
      tick <= ~tick;
      rx_dma_gnt <= rx_dma_req && !rx_dma_gnt && (!slow || tick);
      tx_dma_gnt <= tx_dma_req && !tx_dma_gnt && (!slow || tick);
      rx_dma_ready <= !slow || !tick;
      if (rx_dma_valid && rx_dma_ready) begin
         rx_mem[rx_n] <= rx_dma_data;
         rx_n <= rx_n + 1;
      end
      if (tx_dma_gnt && !tx_dma_valid) tx_dma_valid <= 1'b1;
      if (tx_dma_valid && tx_dma_ready) begin
         ti <= ti + 1;
         tx_dma_valid <= !tx_dma_eop;
      end
   end
   // an idle bus shows a toggling pattern, never a stale word
   assign {tx_dma_eop, tx_dma_byte_en, tx_dma_data} = tx_dma_valid ? tx_mem[ti] :
      {3'h0, {8{tick, ~tick}}};
endmodule // mft_mem_model

// ===== mft_fifo_dma_test.sv
// self-checking bench for the mac fifo threshold block
`timescale 1ns/10ps
module mft_fifo_dma_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   mft_pkg::mft_cfg_t cfg = '0;
   logic rx_byte_valid = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic rx_end = 1'b0;
   logic [15:0] rx_status = 16'h0000;
   logic tx_start = 1'b0;
   logic tx_byte_ready = 1'b0;
   logic slow = 1'b0;
   int done_count = 0;
   logic rx_byte_ready, rx_dma_req, rx_dma_gnt, rx_dma_valid, rx_dma_ready, rx_dma_last;
   logic tx_dma_req, tx_dma_gnt, tx_dma_valid, tx_dma_ready, tx_dma_eop;
   logic tx_byte_valid, tx_packet_done;
   logic [15:0] rx_dma_data, tx_dma_data;
   logic [1:0] tx_dma_byte_en;
   logic [7:0] tx_byte;
   logic [7:0] txq [$];
   int mismatches = 0;
   int check_count = 0;
   mft_fifo_dma i_mft_fifo_dma (.clk, .rst_n, .cfg, .rx_byte_valid, .rx_byte, .rx_byte_ready,
      .rx_end, .rx_status, .rx_dma_req, .rx_dma_gnt, .rx_dma_valid, .rx_dma_ready,
      .rx_dma_data, .rx_dma_last, .tx_start, .tx_dma_req, .tx_dma_gnt, .tx_dma_valid,
      .tx_dma_ready, .tx_dma_data, .tx_dma_byte_en, .tx_dma_eop, .tx_byte_valid, .tx_byte,
      .tx_byte_ready, .tx_packet_done);
   mft_mem_model i_mft_mem_model (.clk, .slow, .rx_dma_req, .rx_dma_gnt, .rx_dma_valid,
      .rx_dma_ready, .rx_dma_data, .tx_dma_req, .tx_dma_gnt, .tx_dma_valid, .tx_dma_ready,
      .tx_dma_data, .tx_dma_byte_en, .tx_dma_eop);
   initial begin
      forever #5 clk = ~clk;
   end
   // serializer side stalls every other cycle in slow mode
   always @(posedge clk) begin
      if (tx_byte_valid && tx_byte_ready) txq.push_back(tx_byte);
      if (tx_packet_done) done_count <= done_count + 1;
      tx_byte_ready <= !slow || !tx_byte_ready;
   end
   task automatic give_verdict;
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic expire(input int k);
      if (k >= 2000) begin
         mismatches++;
         $display("unexpected at %0t: wait ran out", $time);
         give_verdict();
      end
   endtask
   function automatic logic [15:0] lane(input logic be, input logic [7:0] f, s);
      return be ? {f, s} : {s, f};
   endfunction
   task automatic send(input logic [7:0] b);
      int k;
      rx_byte <= b;
      rx_byte_valid <= 1'b1;
      for (k = 0; k < 2000; k++) begin
         @(negedge clk);
         if (rx_byte_ready === 1'b1) break;
      end
      expire(k);
      @(posedge clk);
   endtask
   // 11 bytes at a 4-word threshold: odd end gets a pad, then status
   task automatic rx_case(input logic be, input logic blk);
      int base;
      int i;
      int k;
      logic [15:0] w;
      base = i_mft_mem_model.rx_n;
      cfg <= '{be, blk, 2'h1, 2'h0};
      @(posedge clk);
      for (i = 0; i < 11; i++) begin
         send(8'h10 + 8'(i));
         if (i == 7) begin
            rx_byte_valid <= 1'b0;
            repeat (4) @(posedge clk);
            chk(16'(rx_dma_req), 16'h0000);
         end
      end
      rx_byte_valid <= 1'b0;
      rx_end <= 1'b1;
      rx_status <= 16'hc3a5;
      @(posedge clk);
      rx_end <= 1'b0;
      for (k = 0; k < 2000 && i_mft_mem_model.rx_n < base + 7; k++) @(posedge clk);
      expire(k);
      repeat (10) @(posedge clk);
      chk(16'(i_mft_mem_model.rx_n - base), 16'h0007);
      for (i = 0; i < 5; i++) begin
         w = lane(be, 8'h10 + 8'(2 * i), 8'h11 + 8'(2 * i));
         chk(i_mft_mem_model.rx_mem[base + i], w);
      end
      chk(i_mft_mem_model.rx_mem[base + 5], lane(be, 8'h1a, mft_pkg::PAD_BYTE));
      chk(i_mft_mem_model.rx_mem[base + 6], 16'hc3a5);
   endtask
   // packet starts and ends on odd bytes: first and last memory bytes are extraneous
   task automatic tx_case(input logic be, input logic blk, input logic [1:0] thr);
      int base;
      int i;
      int k;
      int qbase;
      int dbase;
      logic [7:0] m [0:9];
      base = i_mft_mem_model.ti;
      m[0] = 8'hee;
      m[9] = 8'hdd;
      for (i = 0; i < 8; i++) m[i + 1] = 8'h40 + 8'(i);
      for (i = 0; i < 5; i++)
         i_mft_mem_model.tx_mem[base + i] = {i == 4, i == 0 ? 2'h2 : i == 4 ? 2'h1 : 2'h3,
            lane(be, m[2 * i], m[2 * i + 1])};
      qbase = txq.size();
      dbase = done_count;
      cfg <= '{be, blk, 2'h1, thr};
      @(posedge clk);
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      for (k = 0; k < 2000 && done_count == dbase; k++) @(posedge clk);
      expire(k);
      chk(16'(txq.size() - qbase), 16'h0008);
      for (i = 0; i < 8 && qbase + i < txq.size(); i++)
         chk(16'(txq[qbase + i]), 16'h0040 + 16'(i));
      chk(16'(i_mft_mem_model.ti - base), 16'h0005);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rx_case(1'b0, 1'b1);
      slow <= 1'b1;
      rx_case(1'b1, 1'b0);
      tx_case(1'b0, 1'b1, 2'h0);
      slow <= 1'b0;
      tx_case(1'b1, 1'b0, 2'h2);
      give_verdict();
   end
endmodule // mft_fifo_dma_test
